// File: frwsp_pkg.sv
package frwsp_pkg;
    localparam int ADDR_W = 16;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_LOCK = 8'h08;
    localparam logic [7:0] OFF_ZPTR = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
    // ctrl bits
    localparam int CTRL_BUSY_CLR = 0;
    localparam int CTRL_CHIP_ERASE = 1;
    // irq bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_W = 2;
    localparam logic [3:0] LOCK_RST = 4'hf;
    localparam logic [15:0] ZPTR_RST = 16'h0000;
    // lock field decode
    localparam logic [1:0] LK_FREE = 2'b11;
    localparam logic [1:0] LK_NOSTORE = 2'b10;
    localparam logic [1:0] LK_BOTH = 2'b00;
    localparam logic [1:0] LK_NOREAD = 2'b01;
    typedef enum logic [1:0] {
        FRWSP_IDLE = 2'b00,
        FRWSP_RUN = 2'b01,
        FRWSP_DONE = 2'b11
    } frwsp_state_t;
endpackage

// File: frwsp_ctrl.sv
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module frwsp_ctrl #(
    parameter logic [15:0] STALL_START = 16'he000,
    parameter int OP_CYCLES = 200
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [15:0] boot_size_fuses_i,
    input wire logic store_req_i,
    input wire logic [15:0] fetch_pc_i,
    output logic core_halt_o,
    output logic concurrent_region_busy_flag_o,
    output logic read_block_o,
    output logic flash_op_o,
    output logic [15:0] flash_adr_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic in_boot(input logic [15:0] a, input logic [15:0] bnd);
        in_boot = (a >= bnd);
    endfunction

    logic [15:0] boot_start;
    logic wr_stb, rd_stb;
    logic [3:0] lock_reg;
    logic [15:0] zptr_reg;
    logic [frwsp_pkg::IRQ_W-1:0] irq_stat_reg, irq_en_reg;
    frwsp_pkg::frwsp_state_t state_reg;
    logic [15:0] cnt_reg;
    logic tgt_stall_reg;
    logic from_boot, tgt_boot, store_ok, start, done;

    // boot start never below the stalled region start
    assign boot_start = (boot_size_fuses_i < STALL_START) ? STALL_START
                        : boot_size_fuses_i;
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign from_boot = in_boot(fetch_pc_i, boot_start);
    assign tgt_boot = in_boot(zptr_reg, boot_start);
    // app uses lock set 0 (low bits), boot set 1 (high bits)
    always_comb begin
        logic [1:0] lk;
        lk = tgt_boot ? lock_reg[3:2] : lock_reg[1:0];
        store_ok = (lk == frwsp_pkg::LK_FREE) || (lk == frwsp_pkg::LK_NOREAD);
    end
    assign start = store_req_i && (state_reg == frwsp_pkg::FRWSP_IDLE)
                   && from_boot && store_ok;
    assign done = (state_reg == frwsp_pkg::FRWSP_RUN) && (cnt_reg == 16'h0000);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= frwsp_pkg::FRWSP_IDLE;
            cnt_reg <= 16'h0000;
            tgt_stall_reg <= 1'b0;
            flash_adr_o <= 16'h0000;
        end else begin
            case (state_reg)
                frwsp_pkg::FRWSP_IDLE: begin
                    if (start) begin
                        state_reg <= frwsp_pkg::FRWSP_RUN;
                        cnt_reg <= 16'(OP_CYCLES - 1);
                        tgt_stall_reg <= (zptr_reg >= STALL_START);
                        flash_adr_o <= zptr_reg;
                    end
                end
                frwsp_pkg::FRWSP_RUN: begin
                    if (done) begin
                        state_reg <= frwsp_pkg::FRWSP_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                frwsp_pkg::FRWSP_DONE: state_reg <= frwsp_pkg::FRWSP_IDLE;
                default: state_reg <= frwsp_pkg::FRWSP_IDLE;
            endcase
        end
    end

    // halt releases with the operation end, core continues after store
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_halt_o <= 1'b0;
            flash_op_o <= 1'b0;
        end else begin
            flash_op_o <= (state_reg == frwsp_pkg::FRWSP_RUN) && !done;
            if (start && (zptr_reg >= STALL_START)) begin
                core_halt_o <= 1'b1;
            end else if (done) begin
                core_halt_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // busy flag and read block
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            concurrent_region_busy_flag_o <= 1'b0;
            read_block_o <= 1'b0;
        end else begin
            // set wins over clear
            if (start && (zptr_reg < STALL_START)) begin
                concurrent_region_busy_flag_o <= 1'b1;
            end else if (wr_stb && wb_adr_i == frwsp_pkg::OFF_CTRL
                         && wb_dat_i[frwsp_pkg::CTRL_BUSY_CLR]
                         && state_reg == frwsp_pkg::FRWSP_IDLE) begin
                concurrent_region_busy_flag_o <= 1'b0;
            end
            read_block_o <= concurrent_region_busy_flag_o
                            || (start && (zptr_reg < STALL_START));
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_reg <= frwsp_pkg::LOCK_RST;
            zptr_reg <= frwsp_pkg::ZPTR_RST;
            irq_en_reg <= '0;
        end else if (wr_stb) begin
            case (wb_adr_i)
                frwsp_pkg::OFF_LOCK: lock_reg <= lock_reg & wb_dat_i[3:0];
                frwsp_pkg::OFF_ZPTR: if (state_reg == frwsp_pkg::FRWSP_IDLE) begin
                    zptr_reg <= wb_dat_i[15:0];
                end
                frwsp_pkg::OFF_IRQ_EN: irq_en_reg <= wb_dat_i[frwsp_pkg::IRQ_W-1:0];
                frwsp_pkg::OFF_CTRL: if (wb_dat_i[frwsp_pkg::CTRL_CHIP_ERASE]) begin
                    lock_reg <= frwsp_pkg::LOCK_RST;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
        end else begin
            for (int i = 0; i < frwsp_pkg::IRQ_W; i++) begin
                logic set;
                set = (i == frwsp_pkg::IRQ_DONE) ? done
                      : (store_req_i && (state_reg == frwsp_pkg::FRWSP_IDLE) && !start);
                if (set) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (wr_stb && wb_adr_i == frwsp_pkg::OFF_IRQ_CLR && wb_dat_i[i]) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_reg & irq_en_reg);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (rd_stb) begin
                case (wb_adr_i)
                    frwsp_pkg::OFF_STAT: wb_dat_o <= {29'h0, core_halt_o, flash_op_o,
                                                      concurrent_region_busy_flag_o};
                    frwsp_pkg::OFF_LOCK: wb_dat_o <= {28'h0, lock_reg};
                    frwsp_pkg::OFF_ZPTR: wb_dat_o <= {16'h0, zptr_reg};
                    frwsp_pkg::OFF_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat_reg};
                    frwsp_pkg::OFF_IRQ_EN: wb_dat_o <= {30'h0, irq_en_reg};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// File: frwsp_checker.sv
`timescale 1ns/1ps
module frwsp_checker #(parameter logic [15:0] STALL_START = 16'he000) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic store_req_i,
    input wire logic [15:0] fetch_pc_i,
    input wire logic core_halt_o,
    input wire logic concurrent_region_busy_flag_o,
    input wire logic read_block_o,
    input wire logic [15:0] flash_adr_o
);
    // ----
    // bus and sequencer relations
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // repeat count fixed at 8: bench runs with a short op length
    sequence halt_hold; core_halt_o [*8]; endsequence
    sequence halt_end; ##[0:300] !core_halt_o; endsequence
    a_halt_len_bound: assert property ($rose(core_halt_o) |-> halt_hold ##1 halt_end)
        else $error("halt too short or never ends");
    a_halt_stall_only: assert property ($rose(core_halt_o) |-> flash_adr_o >= STALL_START)
        else $error("halt for concurrent target");
    a_busy_conc_run: assert property ($rose(concurrent_region_busy_flag_o)
        |-> flash_adr_o < STALL_START && !core_halt_o)
        else $error("busy set wrongly");
    a_app_store_ignored: assert property (store_req_i && fetch_pc_i < STALL_START
        |=> !$rose(core_halt_o) && !$rose(concurrent_region_busy_flag_o))
        else $error("store from app region started");
    a_busy_flag_sticky: assert property (concurrent_region_busy_flag_o
        && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> concurrent_region_busy_flag_o)
        else $error("busy dropped without software");
    a_busy_blocks_read: assert property (concurrent_region_busy_flag_o |-> read_block_o)
        else $error("busy without read block");
    a_ack_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
endmodule
bind frwsp_ctrl frwsp_checker #(.STALL_START(STALL_START)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .store_req_i(store_req_i), .fetch_pc_i(fetch_pc_i),
    .core_halt_o(core_halt_o), .read_block_o(read_block_o), .flash_adr_o(flash_adr_o),
    .concurrent_region_busy_flag_o(concurrent_region_busy_flag_o));

// File: frwsp_core_model.sv
`timescale 1ns/1ps
module frwsp_core_model (
    input wire logic clk_i,
    input wire logic core_halt_i,
    output logic store_req_o,
    output logic [15:0] fetch_pc_o
);
    initial begin
        store_req_o = 1'h0;
        fetch_pc_o = 16'h0000;
    end
    // a halted core issues nothing for up to 400 cycles; pc stays in the running region
    task automatic store(input logic [15:0] pc);
        int n;
        for (n = 0; n < 400 && core_halt_i; n++) @(posedge clk_i);
        store_req_o <= 1'h1;
        fetch_pc_o <= pc;
        @(posedge clk_i);
        store_req_o <= 1'h0;
        fetch_pc_o <= pc + 16'h0002;
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic wb_we_i = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, store_req_i, core_halt_o, busy, read_block_o, flash_op_o, irq_o;
    logic [15:0] fetch_pc_i, flash_adr_o;
    int bad_count = 0;
    int comparisons = 0;
    always #10 clk_i = ~clk_i;
    frwsp_ctrl #(.OP_CYCLES(10)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'hf),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .boot_size_fuses_i(16'hf000), .store_req_i(store_req_i), .fetch_pc_i(fetch_pc_i),
        .core_halt_o(core_halt_o), .concurrent_region_busy_flag_o(busy),
        .read_block_o(read_block_o), .flash_op_o(flash_op_o), .flash_adr_o(flash_adr_o),
        .irq_o(irq_o));
    frwsp_core_model core (.clk_i(clk_i), .core_halt_i(core_halt_o),
        .store_req_o(store_req_i), .fetch_pc_o(fetch_pc_i));
    // ----
    // tasks
    // ----
    task automatic stop_test();
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'h1) break;
        end
        if (n == 50) begin
            bad_count++;
            stop_test();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    // store, then look once the start has landed
    task automatic st(input logic [15:0] z, input logic [15:0] pc);
        wb(1'h1, frwsp_pkg::OFF_ZPTR, {16'h0, z});
        core.store(pc);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic idle();
        int n;
        for (n = 0; n < 50 && (flash_op_o !== 1'h0 || core_halt_o !== 1'h0); n++)
            @(posedge clk_i);
        if (n == 50) begin
            bad_count++;
            stop_test();
        end
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_app();
        st(16'h1000, 16'h0100);
        chk({core_halt_o, busy, flash_op_o}, 32'h0);
        wb(1'h0, frwsp_pkg::OFF_IRQ_STAT, 32'h0);
        chk(rd, 32'h2);
        wb(1'h1, frwsp_pkg::OFF_IRQ_CLR, 32'h3);
    endtask
    task automatic t_conc();
        st(16'h1000, 16'hf000);
        chk({core_halt_o, busy, read_block_o, flash_adr_o}, {3'h3, 16'h1000});
        idle();
        chk({busy, read_block_o}, 32'h3);
        wb(1'h1, frwsp_pkg::OFF_IRQ_EN, 32'h1);
        chk(irq_o, 32'h1);
        wb(1'h1, frwsp_pkg::OFF_IRQ_CLR, 32'h1);
        chk(irq_o, 32'h0);
        wb(1'h1, frwsp_pkg::OFF_CTRL, 32'h1);
        chk(busy, 32'h0);
    endtask
    // boot region targets itself and lies in the stalled region
    task automatic t_stall();
        st(16'hf000, 16'hf100);
        chk({core_halt_o, busy, flash_adr_o}, {2'h2, 16'hf000});
        wb(1'h0, frwsp_pkg::OFF_STAT, 32'h0);
        chk(rd, 32'h6);
        idle();
        chk({core_halt_o, busy}, 32'h0);
    endtask
    task automatic t_lock();
        wb(1'h1, frwsp_pkg::OFF_LOCK, 32'he);
        st(16'h1000, 16'hf000);
        chk(busy, 32'h0);
        wb(1'h1, frwsp_pkg::OFF_LOCK, 32'h2);
        st(16'hf000, 16'hf000);
        chk(core_halt_o, 32'h0);
        wb(1'h1, frwsp_pkg::OFF_LOCK, 32'hf);
        wb(1'h0, frwsp_pkg::OFF_LOCK, 32'h0);
        chk(rd, 32'h2);
        wb(1'h1, frwsp_pkg::OFF_CTRL, 32'h2);
        wb(1'h1, frwsp_pkg::OFF_LOCK, 32'hd);
        st(16'h1000, 16'hf000);
        chk(busy, 32'h1);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk({core_halt_o, busy, read_block_o, flash_op_o, irq_o}, 32'h0);
        wb(1'h0, frwsp_pkg::OFF_LOCK, 32'h0);
        chk(rd, {28'h0, frwsp_pkg::LOCK_RST});
        wb(1'h0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        t_app();
        t_conc();
        t_stall();
        t_lock();
        stop_test();
    end
endmodule
